// >>> hdl/rtcsv_ctrl.sv
// supervisor control: power-fail warning, century flag, open-drain
// output pin, battery check schedule, recovery deselect, defaults.
// assumes rst_in marks initial power (battery attach) and the analog
// comparators arrive as asynchronous levels.
//
// What this block does
// - warning low while sensed input below threshold
// - supply lost: comparison off, warning held low
// - supply back: warning high through recovery, then follows
// - century enable bit 7, flag bit 6 at 03h
// - enable set toggles flag at turnover, else unchanged
// - plain mode: shared pin follows output bit
// - shared pin only pulls low or releases
// - battery check at power-up and daily
// - low battery sets flag bit 4 at 0fh
// - flag holds until a later check passes
// - battery checks only with main supply present
// - recovery select is bit 7 at 04h
// - recovery time chosen by select and oscillator stop
// - host writes ignored during recovery time
// - initial power defaults for control bits
// - later power-up keeps some bits, clears others, sets halt bit
// - watchdog clear covers all eight bits
`timescale 1ns/100ps
`include "rtcsv_params.svh"

module rtcsv_ctrl #(
  parameter longint REC_LONG_CYC  =
    64'(`RTCSV_REC_LONG_MS) * (64'(`RTCSV_CLK_HZ) / 64'd1000),
  parameter longint REC_SLOW_CYC  =
    64'(`RTCSV_REC_SLOW_MS) * (64'(`RTCSV_CLK_HZ) / 64'd1000),
  parameter longint CHECK_CYC     =
    64'(`RTCSV_CHECK_HOURS) * 64'd3600 * 64'(`RTCSV_CLK_HZ)
) (
  // clock and reset
  input  wire logic       clk_in,
  input  wire logic       rst_in,
  // analog comparator levels
  input  wire logic       vcc_ok_in,
  input  wire logic       power_fail_sense_in,
  input  wire logic       batt_low_in,
  // time keeping
  input  wire logic       year_update_in,
  input  wire logic [7:0] year_in,
  // register port
  input  wire logic       reg_wr_in,
  input  wire logic       reg_rd_in,
  input  wire logic [7:0] reg_addr_in,
  input  wire logic [7:0] reg_wdata_in,
  output logic      [7:0] reg_rdata_out,
  // pins
  output logic            power_fail_warn_out,
  output logic            shared_irq_test_out_pin_out,
  output logic            shared_irq_test_out_pin_oe_n_out,
  // control levels to the rest of the clock
  output logic            halt_update_out,
  output logic            oscillator_stop_out
);

  localparam int TW = 40;
  localparam logic [TW-1:0] REC_SHORT_CYC =
    TW'(`RTCSV_REC_SHORT_US * (`RTCSV_CLK_HZ / 1000000));

  // ---------------------------------------------------------------
  // input synchronisers
  // ---------------------------------------------------------------
  logic [2:0] sync_a;
  logic [2:0] sync_b;
  logic [2:0] async_lv;
  logic       vcc_s;
  logic       pfi_low_s;
  logic       batt_low_s;

  assign async_lv = {batt_low_in, power_fail_sense_in, vcc_ok_in};

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_sync
      always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
          sync_a[gi] <= 1'b0;
          sync_b[gi] <= 1'b0;
        end else begin
          sync_a[gi] <= async_lv[gi];
          sync_b[gi] <= sync_a[gi];
        end
      end
    end
  endgenerate

  assign vcc_s      = sync_b[0];
  assign pfi_low_s  = sync_b[1];
  assign batt_low_s = sync_b[2];

  // ---------------------------------------------------------------
  // supply state
  // ---------------------------------------------------------------
  rtcsv_pkg::rtcsv_pwr_t state;
  rtcsv_pkg::rtcsv_pwr_t next_state;
  logic                  vcc_rise;
  logic                  rec_done;
  logic                  rec_busy;
  logic                  day_done;
  logic                  check_now;
  logic [TW-1:0]         rec_load;

  assign vcc_rise = (state == rtcsv_pkg::RTCSV_PWR_OFF) && vcc_s;

  always_comb begin
    next_state = state;
    unique case (state)
      rtcsv_pkg::RTCSV_PWR_OFF: begin
        if (vcc_s) begin
          next_state = rtcsv_pkg::RTCSV_PWR_RECOVER;
        end
      end
      rtcsv_pkg::RTCSV_PWR_RECOVER: begin
        if (!vcc_s) begin
          next_state = rtcsv_pkg::RTCSV_PWR_OFF;
        end else if (rec_done) begin
          next_state = rtcsv_pkg::RTCSV_PWR_ON;
        end
      end
      rtcsv_pkg::RTCSV_PWR_ON: begin
        if (!vcc_s) begin
          next_state = rtcsv_pkg::RTCSV_PWR_OFF;
        end
      end
      default: begin
        next_state = rtcsv_pkg::RTCSV_PWR_OFF;
      end
    endcase
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      state <= rtcsv_pkg::RTCSV_PWR_OFF;
    end else begin
      state <= next_state;
    end
  end

  // ---------------------------------------------------------------
  // control registers
  // ---------------------------------------------------------------
  logic [7:0] century_year_register;
  logic [7:0] recovery_select_register;
  logic [7:0] control_register;
  logic [7:0] watchdog_register;
  logic [7:0] alarm_register;
  logic [7:0] halt_register;
  logic [7:0] osc_register;
  logic       battery_low_flag;
  logic       wr_ok;
  logic       turnover;
  logic       recovery_time_select;
  logic       oscillator_stop;
  logic       freq_test_enable;
  logic       alarm_irq_enable;
  logic       century_toggle_enable;
  logic       century_flag;
  logic       out_level;

  // writes land only once recovery has ended
  assign wr_ok = reg_wr_in && (state == rtcsv_pkg::RTCSV_PWR_ON);
  assign turnover = year_update_in && (year_in == `RTCSV_YEAR_LAST);

  assign century_toggle_enable = century_year_register[`RTCSV_BIT_CEB];
  assign century_flag          = century_year_register[`RTCSV_BIT_CB];
  assign recovery_time_select  = recovery_select_register[`RTCSV_BIT_TR];
  assign oscillator_stop       = osc_register[`RTCSV_BIT_ST];
  assign freq_test_enable      = control_register[`RTCSV_BIT_FT];
  assign out_level             = control_register[`RTCSV_BIT_OUT];
  assign alarm_irq_enable      = alarm_register[`RTCSV_BIT_AFE];

  // century flag toggles on top of a same-cycle write whose enable bit is set
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      century_year_register <= 8'h00;
    end else begin
      if (wr_ok && reg_addr_in == `RTCSV_OFF_CENTURY) begin
        century_year_register <= reg_wdata_in;
        century_year_register[`RTCSV_BIT_CB] <= reg_wdata_in[`RTCSV_BIT_CB]
          ^ (turnover && reg_wdata_in[`RTCSV_BIT_CEB]);
      end else if (turnover && century_toggle_enable) begin
        century_year_register[`RTCSV_BIT_CB] <= !century_flag;
      end
    end
  end

  // select and stop survive later power-ups, cleared only at reset
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      recovery_select_register <= 8'h00;
      osc_register             <= 8'h00;
    end else begin
      if (wr_ok && reg_addr_in == `RTCSV_OFF_RECOVERY) begin
        recovery_select_register <= reg_wdata_in;
      end
      if (wr_ok && reg_addr_in == `RTCSV_OFF_OSC) begin
        osc_register <= reg_wdata_in;
      end
    end
  end

  // output level kept at later power-up, test bit cleared
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      control_register <= 8'h00;
      control_register[`RTCSV_BIT_OUT] <= 1'b1;
    end else if (vcc_rise) begin
      control_register[`RTCSV_BIT_FT] <= 1'b0;
    end else if (wr_ok && reg_addr_in == `RTCSV_OFF_CONTROL) begin
      control_register <= reg_wdata_in;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      watchdog_register <= `RTCSV_WD_RESET;
      alarm_register    <= 8'h00;
      halt_register     <= 8'h00;
      halt_register[`RTCSV_BIT_HT] <= 1'b1;
    end else if (vcc_rise) begin
      watchdog_register <= `RTCSV_WD_RESET;
      alarm_register[`RTCSV_BIT_AFE]  <= 1'b0;
      alarm_register[`RTCSV_BIT_ABE]  <= 1'b0;
      alarm_register[`RTCSV_BIT_SQUARE_WAVE_ENABLE] <= 1'b0;
      halt_register[`RTCSV_BIT_HT]    <= 1'b1;
    end else if (wr_ok) begin
      if (reg_addr_in == `RTCSV_OFF_WATCHDOG) begin
        watchdog_register <= reg_wdata_in;
      end
      if (reg_addr_in == `RTCSV_OFF_ALARM) begin
        alarm_register <= reg_wdata_in;
      end
      if (reg_addr_in == `RTCSV_OFF_HALT) begin
        halt_register <= reg_wdata_in;
      end
    end
  end

  assign halt_update_out     = halt_register[`RTCSV_BIT_HT];
  assign oscillator_stop_out = oscillator_stop;

  // ---------------------------------------------------------------
  // register read
  // ---------------------------------------------------------------
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      reg_rdata_out <= 8'h00;
    end else if (reg_rd_in) begin
      unique case (reg_addr_in)
        `RTCSV_OFF_CENTURY:  reg_rdata_out <= century_year_register;
        `RTCSV_OFF_RECOVERY: reg_rdata_out <= recovery_select_register;
        `RTCSV_OFF_CONTROL:  reg_rdata_out <= control_register;
        `RTCSV_OFF_WATCHDOG: reg_rdata_out <= watchdog_register;
        `RTCSV_OFF_ALARM:    reg_rdata_out <= alarm_register;
        `RTCSV_OFF_HALT:     reg_rdata_out <= halt_register;
        `RTCSV_OFF_OSC:      reg_rdata_out <= osc_register;
        `RTCSV_OFF_FLAGS: begin
          reg_rdata_out <= 8'h00;
          reg_rdata_out[`RTCSV_BIT_BL] <= battery_low_flag;
        end
        default:             reg_rdata_out <= 8'h00;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // recovery and daily timers
  // ---------------------------------------------------------------
  // with select clear, a stopped oscillator gives the shorter 40 ms window
  assign rec_load = recovery_time_select ? REC_SHORT_CYC :
                    oscillator_stop ? TW'(REC_SLOW_CYC) :
                    TW'(REC_LONG_CYC);

  rtcsv_timer #(.WIDTH(TW)) u_rec_timer (
    .clk_in   (clk_in),
    .rst_in   (rst_in),
    .start_in (vcc_rise),
    .abort_in (!vcc_s),
    .load_in  (rec_load),
    .busy_out (rec_busy),
    .done_out (rec_done)
  );

  // daily count restarts each power-up, dropped in back-up
  rtcsv_timer #(.WIDTH(TW)) u_day_timer (
    .clk_in   (clk_in),
    .rst_in   (rst_in),
    .start_in (vcc_rise || day_done),
    .abort_in (!vcc_s),
    .load_in  (TW'(CHECK_CYC)),
    .busy_out (),
    .done_out (day_done)
  );

  // ---------------------------------------------------------------
  // battery check
  // ---------------------------------------------------------------
  assign check_now = (vcc_rise || day_done) && vcc_s;

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      battery_low_flag <= 1'b0;
    end else if (check_now) begin
      battery_low_flag <= batt_low_s;
    end
  end

  // ---------------------------------------------------------------
  // pins
  // ---------------------------------------------------------------
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      power_fail_warn_out <= 1'b0;
    end else if (!vcc_s) begin
      power_fail_warn_out <= 1'b0;
    end else if (state != rtcsv_pkg::RTCSV_PWR_ON) begin
      power_fail_warn_out <= 1'b1;
    end else begin
      power_fail_warn_out <= !pfi_low_s;
    end
  end

  // other pin functions live elsewhere; here they just release it
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      shared_irq_test_out_pin_oe_n_out <= 1'b1;
    end else begin
      shared_irq_test_out_pin_oe_n_out <= freq_test_enable ||
        alarm_irq_enable || (watchdog_register != `RTCSV_WD_RESET) ||
        out_level;
    end
  end

  assign shared_irq_test_out_pin_out = 1'b0;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  AST_WARN_LOW_OFF: assert property (@(posedge clk_in) disable iff (rst_in)
    !vcc_s |=> !power_fail_warn_out)
    else $error("warning not low without supply");

  AST_WARN_HIGH_REC: assert property (@(posedge clk_in) disable iff (rst_in)
    (state == rtcsv_pkg::RTCSV_PWR_RECOVER && vcc_s) |=> power_fail_warn_out)
    else $error("warning not forced high in recovery");

  AST_WARN_FOLLOW: assert property (@(posedge clk_in) disable iff (rst_in)
    (state == rtcsv_pkg::RTCSV_PWR_ON && vcc_s)
      |=> (power_fail_warn_out == !$past(pfi_low_s)))
    else $error("warning does not follow comparison");

  AST_CB_TOGGLE: assert property (@(posedge clk_in) disable iff (rst_in)
    (turnover && century_toggle_enable && !reg_wr_in)
      |=> (century_flag != $past(century_flag)))
    else $error("century flag missed turnover");

  AST_CB_HOLD: assert property (@(posedge clk_in) disable iff (rst_in)
    (!century_toggle_enable && !reg_wr_in) |=> $stable(century_flag))
    else $error("century flag moved while disabled");

  AST_NO_WRITE_REC: assert property (@(posedge clk_in) disable iff (rst_in)
    (state == rtcsv_pkg::RTCSV_PWR_RECOVER) |=> $stable(control_register))
    else $error("write accepted during recovery");

  AST_PIN_PLAIN: assert property (@(posedge clk_in) disable iff (rst_in)
    (!freq_test_enable && !alarm_irq_enable
      && watchdog_register == `RTCSV_WD_RESET)
      |=> (shared_irq_test_out_pin_oe_n_out == $past(out_level)))
    else $error("shared pin not following output bit");

  AST_BL_SET: assert property (@(posedge clk_in) disable iff (rst_in)
    (check_now && batt_low_s) |=> battery_low_flag ##1 battery_low_flag)
    else $error("battery low not flagged");

  // flag must not move while main supply is absent
  AST_CHECK_SUPPLY: assert property (@(posedge clk_in) disable iff (rst_in)
    !vcc_s |=> $stable(battery_low_flag))
    else $error("battery check without supply");

  AST_UP_DEFAULTS: assert property (@(posedge clk_in) disable iff (rst_in)
    vcc_rise |=> (halt_update_out && !freq_test_enable
      && watchdog_register == `RTCSV_WD_RESET && !alarm_irq_enable))
    else $error("power-up defaults not applied");

  AST_REC_SHORT: assert property (@(posedge clk_in) disable iff (rst_in)
    (vcc_rise && recovery_time_select)
      |-> ##[1:600] (state != rtcsv_pkg::RTCSV_PWR_RECOVER))
    else $error("short recovery overran");

endmodule : rtcsv_ctrl

// >>> hdl/rtcsv_params.svh
// constants for the supervisor control block: offsets, bits, timing
// assumes a 10 MHz core clock and a byte-wide register port
`ifndef RTCSV_PARAMS_SVH
`define RTCSV_PARAMS_SVH

// ---------------------------------------------------------------
// register offsets
// ---------------------------------------------------------------
`define RTCSV_OFF_CENTURY  8'h03
`define RTCSV_OFF_RECOVERY 8'h04
`define RTCSV_OFF_CONTROL  8'h08
`define RTCSV_OFF_WATCHDOG 8'h09
`define RTCSV_OFF_ALARM    8'h0a
`define RTCSV_OFF_HALT     8'h0c
`define RTCSV_OFF_FLAGS    8'h0f
`define RTCSV_OFF_OSC      8'h01

// ---------------------------------------------------------------
// bit positions
// ---------------------------------------------------------------
`define RTCSV_BIT_CEB   7
`define RTCSV_BIT_CB    6
`define RTCSV_BIT_TR    7
`define RTCSV_BIT_OUT   7
`define RTCSV_BIT_FT    6
`define RTCSV_BIT_BL    4
`define RTCSV_BIT_AFE   7
`define RTCSV_BIT_SQUARE_WAVE_ENABLE  6
`define RTCSV_BIT_ABE   5
`define RTCSV_BIT_HT    6
`define RTCSV_BIT_ST    7

// ---------------------------------------------------------------
// values and timing
// ---------------------------------------------------------------
`define RTCSV_YEAR_LAST    8'h99
`define RTCSV_WD_RESET     8'h00
`define RTCSV_CLK_HZ       10000000
`define RTCSV_REC_LONG_MS  96
`define RTCSV_REC_SLOW_MS  40
`define RTCSV_REC_SHORT_US 50
`define RTCSV_CHECK_HOURS  24

`endif

// >>> hdl/rtcsv_pkg.sv
// types shared by the supervisor control block
// assumes nothing beyond the params header
package rtcsv_pkg;

  // ---------------------------------------------------------------
  // supply state, gray coded along off -> recover -> on
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    RTCSV_PWR_OFF     = 2'b00,
    RTCSV_PWR_RECOVER = 2'b01,
    RTCSV_PWR_ON      = 2'b11
  } rtcsv_pwr_t;

endpackage : rtcsv_pkg

// >>> hdl/rtcsv_timer.sv
// down counter with load, abort and a one-cycle done pulse
// assumes load, abort come from logic on the same clock
`timescale 1ns/100ps

module rtcsv_timer #(
  parameter int WIDTH = 40
) (
  // clock and reset
  input  wire logic             clk_in,
  input  wire logic             rst_in,
  // control
  input  wire logic             start_in,
  input  wire logic             abort_in,
  input  wire logic [WIDTH-1:0] load_in,
  // status
  output logic                  busy_out,
  output logic                  done_out
);

  logic [WIDTH-1:0] count;

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      count <= '0;
    end else if (start_in) begin
      count <= load_in;
    end else if (abort_in) begin
      count <= '0;
    end else if (count != '0) begin
      count <= count - WIDTH'(1);
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      done_out <= 1'b0;
    end else begin
      done_out <= (count == WIDTH'(1)) && !start_in && !abort_in;
    end
  end

  assign busy_out = (count != '0);

endmodule : rtcsv_timer

// >>> bench/rtcsv_host.sv
// host model: drives the register port of the supervisor block
// assumes the bench calls its tasks one transfer at a time
`timescale 1ns/100ps
`include "rtcsv_params.svh"

module rtcsv_host (
  // clock
  input  wire logic       clk_in,
  // register port
  output logic            reg_wr_out,
  output logic            reg_rd_out,
  output logic      [7:0] reg_addr_out,
  output logic      [7:0] reg_wdata_out,
  input  wire logic [7:0] reg_rdata_in
);
  logic data_suspect;

  initial begin
    reg_wr_out    = 1'b0;
    reg_rd_out    = 1'b0;
    reg_addr_out  = 8'h00;
    reg_wdata_out = 8'h00;
    data_suspect  = 1'b0;
  end

  // ---------------------------------------------------------------
  // transfers
  // ---------------------------------------------------------------
  // released lines show the inverse so stale values never pass
  task automatic write(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in);
    reg_addr_out  <= a;
    reg_wdata_out <= d;
    reg_wr_out    <= 1'b1;
    @(posedge clk_in);
    reg_wr_out    <= 1'b0;
    reg_addr_out  <= ~a;
    reg_wdata_out <= ~d;
  endtask : write

  task automatic read(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_in);
    reg_addr_out <= a;
    reg_rd_out   <= 1'b1;
    @(posedge clk_in);
    reg_rd_out   <= 1'b0;
    reg_addr_out <= ~a;
    @(posedge clk_in);
    #1 d = reg_rdata_in;
  endtask : read

  // backed-up memory is distrusted when the cell was found low
  task automatic check_backup();
    logic [7:0] f;
    read(`RTCSV_OFF_FLAGS, f);
    data_suspect = f[`RTCSV_BIT_BL];
  endtask : check_backup
endmodule : rtcsv_host

// >>> bench/test_rtc_supervisor_control.sv
// bench for the supervisor control block: registers, power cycles
// assumes design and host model are compiled before this file
`timescale 1ns/100ps
`include "rtcsv_params.svh"

module test_rtc_supervisor_control;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [7:0] mask;
    logic [7:0] exp;
    logic       oe_n;
  } rtcsv_row_t;

  // short counts keep the run small; select=1 is fixed at 500
  localparam longint REC   = 50;
  localparam longint SLOW  = 40;
  localparam longint CHK   = 200;
  localparam int     SHORT = 500;

  logic       clk, rst, vcc_ok, sense, batt_low, year_upd;
  logic [7:0] year, addr, wdata, rdata, rv;
  logic       wr, rd, warn, pin, pin_oe_n, halt, ost;
  int         num_errors;
  int         cmp_count;
  rtcsv_row_t rows [14];

  always #50 clk = ~clk;

  rtcsv_ctrl #(.REC_LONG_CYC(REC), .REC_SLOW_CYC(SLOW),
    .CHECK_CYC(CHK)) rtcsv_ctrl_i (
    .clk_in(clk), .rst_in(rst), .vcc_ok_in(vcc_ok),
    .power_fail_sense_in(sense), .batt_low_in(batt_low),
    .year_update_in(year_upd), .year_in(year),
    .reg_wr_in(wr), .reg_rd_in(rd), .reg_addr_in(addr),
    .reg_wdata_in(wdata), .reg_rdata_out(rdata),
    .power_fail_warn_out(warn), .shared_irq_test_out_pin_out(pin),
    .shared_irq_test_out_pin_oe_n_out(pin_oe_n),
    .halt_update_out(halt), .oscillator_stop_out(ost));

  rtcsv_host rtcsv_host_i (
    .clk_in(clk), .reg_wr_out(wr), .reg_rd_out(rd),
    .reg_addr_out(addr), .reg_wdata_out(wdata), .reg_rdata_in(rdata));

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic bad(input string msg);
    num_errors++;
    $display("BAD t=%0t %s", $time, msg);
  endtask : bad

  task automatic conclude();
    $display("errors %0d checks %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : conclude

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : wait_cyc

  task automatic chk_bit(input logic got, input logic e, input string w);
    cmp_count++;
    if (got !== e) bad(w);
  endtask : chk_bit

  task automatic chk(input logic [7:0] a, input logic [7:0] m,
                     input logic [7:0] e);
    rtcsv_host_i.read(a, rv);
    cmp_count++;
    if ((rv & m) !== e) bad($sformatf("reg %h got %h want %h", a, rv, e));
  endtask : chk

  task automatic year_tick(input logic [7:0] y);
    @(posedge clk);
    year     <= y;
    year_upd <= 1'b1;
    @(posedge clk);
    year_upd <= 1'b0;
  endtask : year_tick

  // level is held past one full check interval
  task automatic set_batt(input logic b, input logic [7:0] e);
    @(posedge clk);
    batt_low <= b;
    wait_cyc(int'(CHK) + 20);
    chk(`RTCSV_OFF_FLAGS, 8'h10, e);
  endtask : set_batt

  task automatic power_down();
    @(posedge clk);
    sense  <= 1'b0;
    vcc_ok <= 1'b0;
    wait_cyc(6);
    chk_bit(warn, 1'b0, "warning not low on supply loss");
  endtask : power_down

  // sense held low-side so the warning drops when recovery ends
  task automatic power_up(input int rec, input logic [7:0] wv,
                          input logic ob);
    int n;
    @(posedge clk);
    sense  <= 1'b1;
    vcc_ok <= 1'b1;
    fork
      begin
        wait_cyc(6);
        chk_bit(warn, 1'b1, "warning not forced high");
        n = 6;
        while (warn === 1'b1 && n < 3000) begin
          wait_cyc(1);
          n++;
        end
      end
      begin
        wait_cyc(12);
        rtcsv_host_i.write(`RTCSV_OFF_CONTROL, wv);
      end
    join
    cmp_count++;
    if (n < rec || n > rec + 12) bad($sformatf("recovery %0d", n));
    if (n >= 3000) conclude();
    chk(`RTCSV_OFF_CONTROL, 8'h80, {ob, 7'h00});
  endtask : power_up

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    clk = 1'b0; rst = 1'b1; vcc_ok = 1'b0; sense = 1'b1;
    batt_low = 1'b0; year_upd = 1'b0; year = 8'h00;
    num_errors = 0; cmp_count = 0;
    rows = '{'{8'h08, 8'h00, 8'hff, 8'h00, 1'b0},
             '{8'h08, 8'h80, 8'hff, 8'h80, 1'b1},
             '{8'h08, 8'h00, 8'hff, 8'h00, 1'b0},
             '{8'h09, 8'h01, 8'hff, 8'h01, 1'b1},
             '{8'h09, 8'h00, 8'hff, 8'h00, 1'b0},
             '{8'h0a, 8'h80, 8'hff, 8'h80, 1'b1},
             '{8'h0a, 8'h00, 8'hff, 8'h00, 1'b0},
             '{8'h08, 8'h40, 8'hff, 8'h40, 1'b1},
             '{8'h08, 8'h00, 8'hff, 8'h00, 1'b0},
             '{8'h03, 8'hc5, 8'hff, 8'hc5, 1'b0},
             '{8'h04, 8'h80, 8'hff, 8'h80, 1'b0},
             '{8'h04, 8'h00, 8'hff, 8'h00, 1'b0},
             '{8'h0f, 8'hff, 8'h10, 8'h00, 1'b0},
             '{8'h20, 8'h5a, 8'hff, 8'h00, 1'b0}};
    wait_cyc(11);
    chk_bit(warn, 1'b0, "warning high in reset");
    chk_bit(pin_oe_n, 1'b1, "pin pulled in reset");
    chk_bit(halt, 1'b1, "halt clear in reset");
    chk_bit(ost, 1'b0, "stop set in reset");
    @(posedge clk);
    rst <= 1'b0;
    wait_cyc(2);
    power_up(int'(REC), 8'h00, 1'b1);
    chk(`RTCSV_OFF_RECOVERY, 8'h80, 8'h00);
    chk(`RTCSV_OFF_WATCHDOG, 8'hff, 8'h00);
    chk(`RTCSV_OFF_ALARM, 8'he0, 8'h00);
    chk(`RTCSV_OFF_HALT, 8'h40, 8'h40);
    for (int i = 0; i < 2; i++) begin
      @(posedge clk);
      sense <= i[0];
      wait_cyc(5);
      chk_bit(warn, ~i[0], "warning does not follow sense");
    end
    foreach (rows[i]) begin
      rtcsv_host_i.write(rows[i].addr, rows[i].wdata);
      chk(rows[i].addr, rows[i].mask, rows[i].exp);
      chk_bit(pin_oe_n, rows[i].oe_n, "shared pin level");
      chk_bit(pin, 1'b0, "shared pin driven high");
    end
    rtcsv_host_i.write(`RTCSV_OFF_CENTURY, 8'h80);
    year_tick(8'h99);
    chk(`RTCSV_OFF_CENTURY, 8'hc0, 8'hc0);
    year_tick(8'h98);
    chk(`RTCSV_OFF_CENTURY, 8'hc0, 8'hc0);
    year_tick(8'h99);
    chk(`RTCSV_OFF_CENTURY, 8'hc0, 8'h80);
    rtcsv_host_i.write(`RTCSV_OFF_CENTURY, 8'h40);
    year_tick(8'h99);
    chk(`RTCSV_OFF_CENTURY, 8'hc0, 8'h40);
    set_batt(1'b1, 8'h10);
    set_batt(1'b0, 8'h00);
    // bits that a later power-up must keep, clear or set
    rtcsv_host_i.write(`RTCSV_OFF_CONTROL, 8'h40);
    rtcsv_host_i.write(`RTCSV_OFF_RECOVERY, 8'h80);
    rtcsv_host_i.write(`RTCSV_OFF_OSC, 8'h80);
    rtcsv_host_i.write(`RTCSV_OFF_ALARM, 8'he0);
    rtcsv_host_i.write(`RTCSV_OFF_WATCHDOG, 8'hff);
    rtcsv_host_i.write(`RTCSV_OFF_HALT, 8'h00);
    wait_cyc(1);
    chk_bit(halt, 1'b0, "halt level not written");
    chk_bit(ost, 1'b1, "stop level not written");
    power_down();
    set_batt(1'b1, 8'h00);
    power_up(SHORT, 8'h80, 1'b0);
    chk(`RTCSV_OFF_CONTROL, 8'hc0, 8'h00);
    chk(`RTCSV_OFF_RECOVERY, 8'h80, 8'h80);
    chk(`RTCSV_OFF_OSC, 8'h80, 8'h80);
    chk(`RTCSV_OFF_ALARM, 8'he0, 8'h00);
    chk(`RTCSV_OFF_WATCHDOG, 8'hff, 8'h00);
    chk(`RTCSV_OFF_HALT, 8'h40, 8'h40);
    chk_bit(halt, 1'b1, "halt not set on power-up");
    chk_bit(ost, 1'b1, "stop not kept on power-up");
    chk(`RTCSV_OFF_FLAGS, 8'h10, 8'h10);
    rtcsv_host_i.check_backup();
    chk_bit(rtcsv_host_i.data_suspect, 1'b1, "backup not distrusted");
    rtcsv_host_i.write(`RTCSV_OFF_RECOVERY, 8'h00);
    power_down();
    power_up(int'(SLOW), 8'h80, 1'b0);
    conclude();
  end
endmodule : test_rtc_supervisor_control
